// ==== rcm_pkg.sv ====
// Package for the real-time counter core: register map, fields, reset values, carrier types
package rcm_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SRC = 4'h1;
  localparam logic [3:0] OFS_PS0_CTRL = 4'h2;
  localparam logic [3:0] OFS_PS1_CTRL = 4'h3;
  localparam logic [3:0] OFS_PS0_CNT = 4'h4;
  localparam logic [3:0] OFS_PS1_CNT = 4'h5;
  localparam logic [3:0] OFS_COUNT_0 = 4'h8;
  localparam logic [3:0] OFS_COUNT_1 = 4'h9;
  localparam logic [3:0] OFS_COUNT_2 = 4'hA;
  localparam logic [3:0] OFS_COUNT_3 = 4'hB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Main control register
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_HALT_BIT = 6;
  localparam int CTRL_IE_BIT = 5;
  localparam int CTRL_FLAG_BIT = 4;
  localparam int CTRL_RDY_BIT = 3;
  localparam int CTRL_RDY_FLAG_BIT = 2;
  localparam int CTRL_TEV_LSB = 0;
  // Source register
  localparam int SRC_SEL_LSB = 0;
  localparam int SRC_RDY_IE_BIT = 2;
  // Prescaler control registers
  localparam int PS_DIV_LSB = 0;
  localparam int PS_HALT_BIT = 3;
  localparam int PS_CASC_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TEV_8 = 2'b00,
    TEV_16 = 2'b01,
    TEV_24 = 2'b10,
    TEV_32 = 2'b11
  } rcm_tev_type;

  typedef enum logic [1:0] {
    SRC_AUX = 2'b00,
    SRC_SUB = 2'b01,
    SRC_PS1 = 2'b10,
    SRC_PS1_ALT = 2'b11
  } rcm_src_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rcm_bus_req_type;

endpackage : rcm_pkg

// ==== rcm_core.sv ====
// Real-time clock unit run as a 32-bit general-purpose counter with two prescalers
// Functional notes
// - Counter runs only while calendar mode select is clear.
// - Leaving calendar mode clears all count bytes and both prescalers.
// - Counter clock is aux, subsystem, or a prescaled version of either.
// - First prescaler divides aux, second divides subsystem; taps /2 to /256.
// - First prescaler may feed the second; cascaded output can clock counter.
// - Four 8-bit bytes chained; each advances when the one below wraps.
// - Trigger select picks 8, 16, 24 or 32-bit overflow as event.
// - Event sets flag; interrupt request only while trigger irq enable set.
// - Each count byte is read and written on its own.
// - Prescalers work as two 8-bit counters or one 16-bit cascade.
// - Each prescaler halt bit stops it and holds its value.
// - When cascaded, first prescaler halt stops both prescalers.
// - Counter on aux or subsystem clock stops on counter halt.
// - Counter on second prescaler stops on its halt or counter halt.
// - Counter on cascade stops on either prescaler halt or counter halt.
// - Writes to count bytes or prescalers take effect at once.
// - In counter mode ready bit and flag stay clear, enable ignored.
module rcm_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic aux_clock,
  input wire logic subsystem_clock,
  input wire rcm_pkg::rcm_bus_req_type bus_req,
  output logic [rcm_pkg::DATA_W-1:0] rd_data,
  output logic trigger_irq
);
  import rcm_pkg::*;

  // ----------------------------------------------------------------
  // Clock pin synchronisers and edge ticks
  // ----------------------------------------------------------------
  logic aux_meta;
  logic aux_sync;
  logic aux_prev;
  logic sub_meta;
  logic sub_sync;
  logic sub_prev;
  wire aux_tick = aux_sync & ~aux_prev;
  wire sub_tick = sub_sync & ~sub_prev;

  // Two stages, then a delay stage for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {aux_meta, aux_sync, aux_prev} <= 3'b000;
      {sub_meta, sub_sync, sub_prev} <= 3'b000;
    end else begin
      {aux_meta, aux_sync, aux_prev} <= {aux_clock, aux_meta, aux_sync};
      {sub_meta, sub_sync, sub_prev} <= {subsystem_clock, sub_meta, sub_sync};
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic calendar_mode_select;
  logic counter_halt;
  logic trigger_event_irq_enable;
  logic trigger_event_flag;
  rcm_tev_type trigger_event_select;
  rcm_src_type count_src;
  logic calendar_ready_irq_enable;
  logic [2:0] ps0_div;
  logic first_prescaler_halt;
  logic [2:0] ps1_div;
  logic second_prescaler_halt;
  logic ps1_cascade;
  logic [7:0] first_prescaler;
  logic [7:0] second_prescaler;
  logic [3:0][7:0] count_bytes;

  // Calendar ready status and its flag stay clear in counter mode
  wire calendar_ready = 1'b0;
  wire calendar_ready_flag = 1'b0;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
  wire wr_src = bus_req.wr && (bus_req.addr == OFS_SRC);
  wire wr_ps0_ctrl = bus_req.wr && (bus_req.addr == OFS_PS0_CTRL);
  wire wr_ps1_ctrl = bus_req.wr && (bus_req.addr == OFS_PS1_CTRL);
  wire wr_ps0_cnt = bus_req.wr && (bus_req.addr == OFS_PS0_CNT);
  wire wr_ps1_cnt = bus_req.wr && (bus_req.addr == OFS_PS1_CNT);
  wire wr_count_any = bus_req.wr && (bus_req.addr[3:2] == OFS_COUNT_0[3:2]);
  wire [1:0] wr_byte_sel = bus_req.addr[1:0];

  // Leaving calendar mode on a control write
  wire mode_to_counter = wr_ctrl && calendar_mode_select && !bus_req.data[CTRL_MODE_BIT];
  wire running = !calendar_mode_select;

  // ----------------------------------------------------------------
  // Prescaler ticks, halts and tap outputs
  // ----------------------------------------------------------------
  // Cascade halt: first prescaler halt also stops the second
  wire ps0_halt_eff = first_prescaler_halt;
  wire ps1_halt_eff = second_prescaler_halt | (ps1_cascade & first_prescaler_halt);
  wire ps0_inc = running && aux_tick && !ps0_halt_eff;
  // Tap /2^(n+1) fires when bits n..0 are all ones as the count advances
  wire [7:0] ps0_low_ones = {&first_prescaler[7:0], &first_prescaler[6:0],
    &first_prescaler[5:0], &first_prescaler[4:0], &first_prescaler[3:0],
    &first_prescaler[2:0], &first_prescaler[1:0], first_prescaler[0]};
  wire ps0_out = ps0_inc && ps0_low_ones[ps0_div];
  wire ps1_in = ps1_cascade ? ps0_out : sub_tick;
  wire ps1_inc = running && ps1_in && !ps1_halt_eff;
  wire [7:0] ps1_low_ones = {&second_prescaler[7:0], &second_prescaler[6:0],
    &second_prescaler[5:0], &second_prescaler[4:0], &second_prescaler[3:0],
    &second_prescaler[2:0], &second_prescaler[1:0], second_prescaler[0]};
  wire ps1_out = ps1_inc && ps1_low_ones[ps1_div];

  // ----------------------------------------------------------------
  // Main counter clock select, halts and overflow events
  // ----------------------------------------------------------------
  wire src_is_ps = (count_src == SRC_PS1) || (count_src == SRC_PS1_ALT);
  // Effective halt by source: direct, second prescaler, or cascade
  wire count_halt_eff = counter_halt
    | (src_is_ps & second_prescaler_halt)
    | (src_is_ps & ps1_cascade & first_prescaler_halt);
  wire count_tick = (count_src == SRC_AUX) ? aux_tick :
    (count_src == SRC_SUB) ? sub_tick : ps1_out;
  wire count_inc = running && count_tick && !count_halt_eff;
  wire [31:0] count_flat = count_bytes;
  wire [31:0] count_plus = count_flat + 32'h0000_0001;
  wire ovf_8 = count_bytes[0] == ALL_ONES_BYTE;
  wire ovf_16 = ovf_8 && (count_bytes[1] == ALL_ONES_BYTE);
  wire ovf_24 = ovf_16 && (count_bytes[2] == ALL_ONES_BYTE);
  wire ovf_32 = ovf_24 && (count_bytes[3] == ALL_ONES_BYTE);
  logic ovf_sel;
  always_comb begin
    unique case (trigger_event_select)
      TEV_8: ovf_sel = ovf_8;
      TEV_16: ovf_sel = ovf_16;
      TEV_24: ovf_sel = ovf_24;
      TEV_32: ovf_sel = ovf_32;
    endcase
  end
  wire trig_event = count_inc && ovf_sel;
  // Software clears the flag by writing zero; a new event wins
  wire next_flag = trig_event |
    (trigger_event_flag & !(wr_ctrl && !bus_req.data[CTRL_FLAG_BIT]));

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      calendar_mode_select <= 1'b0;
      counter_halt <= 1'b0;
      trigger_event_irq_enable <= 1'b0;
      trigger_event_select <= TEV_8;
    end else if (wr_ctrl) begin
      calendar_mode_select <= bus_req.data[CTRL_MODE_BIT];
      counter_halt <= bus_req.data[CTRL_HALT_BIT];
      trigger_event_irq_enable <= bus_req.data[CTRL_IE_BIT];
      trigger_event_select <= rcm_tev_type'(bus_req.data[CTRL_TEV_LSB +: 2]);
    end
  end

  // Source select and prescaler controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_src <= SRC_AUX;
      calendar_ready_irq_enable <= 1'b0;
      {first_prescaler_halt, ps0_div} <= 4'h0;
      {ps1_cascade, second_prescaler_halt, ps1_div} <= 5'h00;
    end else begin
      if (wr_src) begin
        count_src <= rcm_src_type'(bus_req.data[SRC_SEL_LSB +: 2]);
        calendar_ready_irq_enable <= bus_req.data[SRC_RDY_IE_BIT];
      end
      if (wr_ps0_ctrl) begin
        {first_prescaler_halt, ps0_div} <= bus_req.data[PS_HALT_BIT:PS_DIV_LSB];
      end
      if (wr_ps1_ctrl) begin
        {ps1_cascade, second_prescaler_halt, ps1_div} <= bus_req.data[PS_CASC_BIT:PS_DIV_LSB];
      end
    end
  end

  // Trigger event flag and registered interrupt request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_event_flag <= 1'b0;
      trigger_irq <= 1'b0;
    end else begin
      trigger_event_flag <= next_flag;
      trigger_irq <= trigger_event_flag & trigger_event_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler counters: mode clear, immediate write, else advance
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_prescaler <= RST_BYTE;
      second_prescaler <= RST_BYTE;
    end else if (mode_to_counter) begin
      first_prescaler <= RST_BYTE;
      second_prescaler <= RST_BYTE;
    end else begin
      if (wr_ps0_cnt) begin
        first_prescaler <= bus_req.data;
      end else if (ps0_inc) begin
        first_prescaler <= first_prescaler + 8'h01;
      end
      if (wr_ps1_cnt) begin
        second_prescaler <= bus_req.data;
      end else if (ps1_inc) begin
        second_prescaler <= second_prescaler + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Count bytes: a write to one byte overrides that byte's advance
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_bytes <= RST_COUNT;
    end else if (mode_to_counter) begin
      count_bytes <= RST_COUNT;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_count_any && (wr_byte_sel == 2'(i))) begin
          count_bytes[i] <= bus_req.data;
        end else if (count_inc) begin
          count_bytes[i] <= count_plus[8*i +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path: data stand one cycle after the read strobe
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_req.addr)
      OFS_CTRL: rd_mux = {calendar_mode_select, counter_halt, trigger_event_irq_enable,
        trigger_event_flag, calendar_ready, calendar_ready_flag, trigger_event_select};
      OFS_SRC: rd_mux = {5'h00, calendar_ready_irq_enable, count_src};
      OFS_PS0_CTRL: rd_mux = {4'h0, first_prescaler_halt, ps0_div};
      OFS_PS1_CTRL: rd_mux = {3'h0, ps1_cascade, second_prescaler_halt, ps1_div};
      OFS_PS0_CNT: rd_mux = first_prescaler;
      OFS_PS1_CNT: rd_mux = second_prescaler;
      OFS_COUNT_0: rd_mux = count_bytes[0];
      OFS_COUNT_1: rd_mux = count_bytes[1];
      OFS_COUNT_2: rd_mux = count_bytes[2];
      OFS_COUNT_3: rd_mux = count_bytes[3];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_mode_clear: assert property ($past(mode_to_counter) |-> count_flat == 32'h0 &&
    first_prescaler == 8'h00 && second_prescaler == 8'h00)
    else $error("Counts not cleared on entry to counter mode");

  a_calendar_frozen: assert property (calendar_mode_select && !wr_count_any
    && !mode_to_counter |=> count_flat == $past(count_flat))
    else $error("Counter advanced in calendar mode");

  a_halt_holds: assert property (count_halt_eff && !wr_count_any && !mode_to_counter
    |=> $stable(count_flat))
    else $error("Halted counter changed");

  a_ps_halt_holds: assert property (first_prescaler_halt && !wr_ps0_cnt && !mode_to_counter
    |=> $stable(first_prescaler))
    else $error("Halted first prescaler changed");

  a_cascade_halt: assert property (ps1_cascade && first_prescaler_halt && !wr_ps1_cnt
    && !mode_to_counter |=> $stable(second_prescaler))
    else $error("Second prescaler ran while cascade halted");

  a_event_flag: assert property (trig_event |=> trigger_event_flag ##1
    (trigger_irq == $past(trigger_event_irq_enable)))
    else $error("Overflow event did not set flag or request");

  a_irq_gate: assert property (trigger_irq |-> $past(trigger_event_flag)
    && $past(trigger_event_irq_enable))
    else $error("Interrupt without enabled flag");

  a_full_wrap: assert property (count_inc && ovf_32 && !wr_count_any && !mode_to_counter
    |=> count_flat == 32'h0)
    else $error("Full count did not wrap to zero");

  a_byte_write: assert property (wr_count_any && !mode_to_counter
    |=> count_bytes[$past(wr_byte_sel)] == $past(bus_req.data))
    else $error("Count byte write not immediate");

  a_ready_clear: assert property (bus_req.rd && bus_req.addr == OFS_CTRL
    |=> rd_data[CTRL_RDY_BIT:CTRL_RDY_FLAG_BIT] == 2'b00)
    else $error("Ready status read nonzero in counter mode");

  // Prescaler steps and halts, source halts and the flag handshake with software
  a_ps1_halt_holds: assert property (second_prescaler_halt && !wr_ps1_cnt
    && !mode_to_counter |=> $stable(second_prescaler))
    else $error("Halted second prescaler changed");

  a_ps_step: assert property (ps0_inc && !wr_ps0_cnt && !mode_to_counter
    |=> first_prescaler == $past(first_prescaler) + 8'h01)
    else $error("First prescaler missed an auxiliary tick");

  a_cascade_feed: assert property (ps1_cascade && ps0_out && !ps1_halt_eff && !wr_ps1_cnt
    |=> second_prescaler == $past(second_prescaler) + 8'h01)
    else $error("Cascaded second prescaler missed a tap pulse");

  a_src_halt: assert property (src_is_ps && second_prescaler_halt && !wr_count_any
    && !mode_to_counter |=> $stable(count_flat))
    else $error("Counter moved while second prescaler halted");

  a_irq_follows: assert property (trigger_event_flag && trigger_event_irq_enable
    |=> trigger_irq)
    else $error("Enabled flag raised no request");

  a_flag_clear: assert property (wr_ctrl && !bus_req.data[CTRL_FLAG_BIT] && !trig_event
    |=> !trigger_event_flag)
    else $error("Trigger flag not cleared by software");

  c_event_irq: cover property (trig_event ##1 trigger_event_flag ##1 trigger_irq);
  c_cascade_count: cover property (ps1_cascade && src_is_ps && count_inc);
  c_mode_clear: cover property (mode_to_counter);
  c_wrap_24: cover property (trig_event && trigger_event_select == TEV_24);
  c_alt_source: cover property (count_src == SRC_PS1_ALT && count_inc);

endmodule : rcm_core

// ==== tb_rcm_core.sv ====
// Self-checking testbench for the real-time counter core in counter mode
module tb_rcm_core;
  timeunit 1ns;
  timeprecision 1ps;
  import rcm_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic aux_clock = 1'b0;
  logic subsystem_clock = 1'b0;
  rcm_bus_req_type bus_req = '0;
  logic [DATA_W-1:0] rd_data;
  logic trigger_irq;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [31:0] cnt;
  logic [31:0] got;
  logic [31:0] mask;
  logic [3:0] ofs [11] = '{OFS_CTRL, OFS_SRC, OFS_PS0_CTRL, OFS_PS1_CTRL, OFS_PS0_CNT,
    OFS_PS1_CNT, OFS_COUNT_0, OFS_COUNT_1, OFS_COUNT_2, OFS_COUNT_3, 4'hC};

  rcm_core DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .aux_clock(aux_clock),
    .subsystem_clock(subsystem_clock),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .trigger_irq(trigger_irq)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;

  // Cut a hang short well above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons: %0d, mismatches: %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Single-cycle write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.data <= d;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  // Single-cycle read strobe, data sampled in the following cycle
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : bus_rd

  task automatic wr_count(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFS_COUNT_0 + 4'(i), v[8*i +: 8]);
    end
  endtask : wr_count

  task automatic rd_count(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      bus_rd(OFS_COUNT_0 + 4'(i), b);
      v[8*i +: 8] = b;
    end
  endtask : rd_count

  // Pin pulses three cycles high and four low, then settle time
  task automatic pulse(input logic sub, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (sub) begin
        subsystem_clock <= 1'b1;
      end else begin
        aux_clock <= 1'b1;
      end
      repeat (3) @(posedge sys_clk);
      aux_clock <= 1'b0;
      subsystem_clock <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  function automatic logic [7:0] ctrl_val(input logic mode, input logic halt, input logic ie,
                                          input logic [1:0] tev);
    ctrl_val = {mode, halt, ie, 3'b000, tev};
  endfunction : ctrl_val

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rv = 8'($urandom(14));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, including an unmapped place
    foreach (ofs[i]) begin
      bus_rd(ofs[i], rv);
      check(rv, 8'h00);
    end
    // Read-only ready bits and ignored unmapped write
    bus_wr(OFS_CTRL, 8'h0C);
    bus_wr(OFS_SRC, 8'h04);
    bus_wr(4'hC, 8'hA5);
    bus_rd(OFS_CTRL, rv);
    check(rv, 8'h00);
    bus_rd(4'hC, rv);
    check(rv, 8'h00);
    // Each count byte read and written on its own, random data
    for (int i = 0; i < 16; i++) begin
      cnt[7:0] = 8'($urandom);
      bus_wr(OFS_COUNT_0 + 4'(i % 4), cnt[7:0]);
      bus_rd(OFS_COUNT_0 + 4'(i % 4), rv);
      check(rv, cnt[7:0]);
    end
    // Auxiliary-clock counting with random starts and a carry corner
    for (int i = 0; i < 4; i++) begin
      cnt = (i == 0) ? 32'h00FF_FFFE : 32'($urandom);
      wr_count(cnt);
      pulse(1'b0, 5);
      rd_count(got);
      check(got, cnt + 32'h5);
    end
    // Each trigger width: no event one tick early, event on its overflow
    for (int t = 0; t < 4; t++) begin
      mask = 32'hFFFF_FFFF >> (8 * (3 - t));
      bus_wr(OFS_CTRL, ctrl_val(1'b0, 1'b0, t[0], 2'(t)));
      wr_count(mask - 32'h1);
      pulse(1'b0, 1);
      bus_rd(OFS_CTRL, rv);
      check(rv[CTRL_FLAG_BIT], 1'b0);
      pulse(1'b0, 1);
      bus_rd(OFS_CTRL, rv);
      check(rv[CTRL_FLAG_BIT], 1'b1);
      check(trigger_irq, t[0]);
      rd_count(got);
      check(got, mask + 32'h1);
    end
    // Clearing the flag drops the request
    bus_wr(OFS_CTRL, ctrl_val(1'b0, 1'b0, 1'b1, TEV_32));
    repeat (2) @(posedge sys_clk);
    #1;
    check(trigger_irq, 1'b0);
    // Counter halt on aux, then subsystem source with and without halt
    cnt = 32'($urandom);
    wr_count(cnt);
    bus_wr(OFS_CTRL, ctrl_val(1'b0, 1'b1, 1'b0, TEV_8));
    pulse(1'b0, 3);
    rd_count(got);
    check(got, cnt);
    bus_wr(OFS_SRC, 8'h01);
    pulse(1'b1, 3);
    rd_count(got);
    check(got, cnt);
    bus_wr(OFS_CTRL, ctrl_val(1'b0, 1'b0, 1'b0, TEV_8));
    pulse(1'b1, 3);
    rd_count(got);
    check(got, cnt + 32'h3);
    // Cascaded taps: the second prescaler steps once per 2^(n+1) aux ticks
    bus_wr(OFS_PS1_CTRL, 8'h10);
    for (int n = 0; n < 8; n++) begin
      bus_wr(OFS_PS0_CTRL, 8'(n));
      bus_wr(OFS_PS0_CNT, 8'h00);
      bus_wr(OFS_PS1_CNT, 8'h00);
      pulse(1'b0, (2 << n) - 1);
      bus_rd(OFS_PS1_CNT, rv);
      check(rv, 8'h00);
      pulse(1'b0, 1);
      bus_rd(OFS_PS1_CNT, rv);
      check(rv, 8'h01);
      bus_rd(OFS_PS0_CNT, rv);
      check(rv, 8'((2 << n) & 8'hFF));
    end
    // Counter on the cascade: /2 then /2 gives one count per four ticks
    bus_wr(OFS_PS0_CTRL, 8'h00);
    bus_wr(OFS_PS0_CNT, 8'h00);
    bus_wr(OFS_PS1_CNT, 8'h00);
    bus_wr(OFS_SRC, 8'h02);
    wr_count(32'h0);
    pulse(1'b0, 8);
    rd_count(got);
    check(got, 32'h2);
    // First prescaler halt freezes both prescalers and the counter
    bus_wr(OFS_PS0_CTRL, 8'h08);
    pulse(1'b0, 4);
    bus_rd(OFS_PS0_CNT, rv);
    check(rv, 8'h08);
    bus_rd(OFS_PS1_CNT, rv);
    check(rv, 8'h04);
    rd_count(got);
    check(got, 32'h2);
    // Second prescaler halt: first keeps counting, the rest hold
    bus_wr(OFS_PS0_CTRL, 8'h00);
    bus_wr(OFS_PS1_CTRL, 8'h18);
    pulse(1'b0, 4);
    bus_rd(OFS_PS0_CNT, rv);
    check(rv, 8'h0C);
    rd_count(got);
    check(got, 32'h2);
    // Uncascaded second prescaler counts the subsystem clock, alternate source code
    bus_wr(OFS_SRC, 8'h03);
    bus_wr(OFS_PS1_CTRL, 8'h00);
    pulse(1'b1, 4);
    bus_rd(OFS_PS1_CNT, rv);
    check(rv, 8'h08);
    bus_rd(OFS_PS0_CNT, rv);
    check(rv, 8'h0C);
    rd_count(got);
    check(got, 32'h4);
    // Calendar mode freezes counting; leaving it clears the count and both prescalers
    bus_wr(OFS_SRC, 8'h00);
    bus_wr(OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0, TEV_8));
    pulse(1'b0, 3);
    rd_count(got);
    check(got, 32'h4);
    bus_wr(OFS_CTRL, ctrl_val(1'b0, 1'b0, 1'b0, TEV_8));
    rd_count(got);
    check(got, 32'h0);
    bus_rd(OFS_PS0_CNT, rv);
    check(rv, 8'h00);
    bus_rd(OFS_PS1_CNT, rv);
    check(rv, 8'h00);
    wrap_up();
  end
endmodule : tb_rcm_core
